// *** rtl/rspc_defines.svh ***
// constants for the reset, strap and park control block
`ifndef RSPC_DEFINES_SVH
`define RSPC_DEFINES_SVH

`define RSPC_CLK_PERIOD_NS    50
`define RSPC_STRAP_DELAY_NS   1500
// sample delay in cycles; a nominal figure, so exact division
`define RSPC_STRAP_CYCLES     (`RSPC_STRAP_DELAY_NS / `RSPC_CLK_PERIOD_NS)
`define RSPC_STRAP_WIDTH      8
`define RSPC_STRAP_RESET      8'h00
`define RSPC_CNT_WIDTH        6
`define RSPC_PARK_CYCLES      16

`endif

// *** rtl/rspc_pkg.sv ***
// types for the reset, strap and park control block
package rspc_pkg;

   typedef enum logic [2:0]
   {
      RSPC_HELD    = 3'b000,
      RSPC_WAIT    = 3'b001,
      RSPC_CONFIG  = 3'b010,
      RSPC_RUN     = 3'b011,
      RSPC_PARKING = 3'b100,
      RSPC_PARKED  = 3'b101
   } rspc_state_t;

   typedef struct packed
   {
      logic [7:0] data;
      logic [7:0] oe_n;
   } rspc_strap_drive_t;

endpackage : rspc_pkg

// *** rtl/rspc_park_timer.sv ***
// park duration counter used by the control block
`timescale 1ns/100ps
`include "rspc_defines.svh"

module rspc_park_timer
#(
   parameter int CYCLES = `RSPC_PARK_CYCLES
)
(
   input  wire logic CLK_IN,
   input  wire logic clear_in,
   input  wire logic start_in,
   output logic      done_out
);

   logic [7:0] count;
   logic       running;

   always_ff @(posedge CLK_IN)
   begin
      if (clear_in)
      begin
         count   <= 8'h00;
         running <= 1'b0;
         done_out <= 1'b0;
      end
      else if (start_in && !running && !done_out)
      begin
         count   <= 8'h00;
         running <= 1'b1;
      end
      else if (running)
      begin
         count <= count + 8'h01;
         if (count == 8'(CYCLES - 1))
         begin
            running  <= 1'b0;
            done_out <= 1'b1;
         end
      end
   end

endmodule : rspc_park_timer

// *** rtl/rspc_ctrl.sv ***
// reset, test-strap sampling and fast-park control
//
// Function
// R1: rising reset starts self-configuration
// R2: outputs inactive while reset held low
// R3: reset released after supplies, clocks stable
// R4: strap pins high impedance during reset
// R5: sample straps 1.5 us after release
// R6: straps become driven outputs after sampling
// R7: high strap may select test mode
// R8: low park request parks array quickly
// R9: fast park only when normal impossible
// R10: manufacturing test enable held low
// R11: scan port reset held low
// R12: driver enable low after parking done
// R13: strap sample held until next reset
`timescale 1ns/100ps
`include "rspc_defines.svh"

module rspc_ctrl
#(
   parameter int STRAP_CYCLES = `RSPC_STRAP_CYCLES,
   parameter int PARK_CYCLES  = `RSPC_PARK_CYCLES
)
(
   input  wire logic                 CLK_IN,
   input  wire logic                 SYS_RST_IN,
   input  wire logic                 POWER_ON_RESET_N_IN,
   input  wire logic                 FAST_PARK_REQ_N_IN,
   input  wire logic                 MFG_TEST_ENABLE_IN,
   input  wire logic                 SCAN_PORT_RESET_N_IN,
   input  wire logic [7:0]           TEST_STRAP_IN,
   input  wire logic [7:0]           TEST_OBSERVE_IN,
   output rspc_pkg::rspc_strap_drive_t TEST_STRAP_OUT,
   output logic [7:0]                TEST_MODE_OUT,
   output logic                      TEST_MODE_ACTIVE_OUT,
   output logic                      CONFIG_START_OUT,
   output logic                      CONFIG_ACTIVE_OUT,
   output logic                      PARK_ACTIVE_OUT,
   output logic                      ARRAY_DRIVER_ENABLE_RESET_N_OUT,
   output logic                      NORMAL_OP_FAULT_OUT
);
   import rspc_pkg::*;

   // =====================================================
   // sequencing
   // =====================================================
   rspc_state_t             state;
   rspc_state_t             next_state;
   logic [`RSPC_CNT_WIDTH-1:0] count;
   logic                    por_prev;
   logic                    park_done;
   wire                     por_low   = !POWER_ON_RESET_N_IN;
   wire                     por_rise  = POWER_ON_RESET_N_IN && !por_prev;
   wire                     wait_done = (count == `RSPC_CNT_WIDTH'(STRAP_CYCLES - 1));
   wire                     park_req  = !FAST_PARK_REQ_N_IN;
   wire                     live      = (state == RSPC_CONFIG) || (state == RSPC_RUN);
   wire                     parking     = (state == RSPC_PARKING);
   wire                     strap_take  = (state == RSPC_WAIT) && wait_done;
   wire                     park_clear  = SYS_RST_IN || por_low;
   // enable must outlive the park; dropping it early strands the mirrors
   wire                     keep_enable = live || parking;

   always_comb
   begin
      next_state = state;
      unique case (state)
         RSPC_HELD:    next_state = por_rise ? RSPC_WAIT : RSPC_HELD; // R1
         RSPC_WAIT:    next_state = wait_done ? RSPC_CONFIG : RSPC_WAIT; // R5
         RSPC_CONFIG:  next_state = park_req ? RSPC_PARKING : RSPC_RUN;
         RSPC_RUN:     next_state = park_req ? RSPC_PARKING : RSPC_RUN; // R8
         RSPC_PARKING: next_state = park_done ? RSPC_PARKED : RSPC_PARKING;
         RSPC_PARKED:  next_state = RSPC_PARKED;
         default:      next_state = RSPC_HELD;
      endcase
   end

   always_ff @(posedge CLK_IN)
   begin
      if (SYS_RST_IN)
      begin
         state    <= RSPC_HELD;
         count    <= '0;
         por_prev <= 1'b0;
      end
      else
      begin
         por_prev <= POWER_ON_RESET_N_IN;
         // reset low overrides everything, including a park in progress
         state    <= por_low ? RSPC_HELD : next_state; // R2
         count    <= (state == RSPC_WAIT) ? count + 1'b1 : '0;
      end
   end

   // =====================================================
   // strap capture and pin drive
   // =====================================================
   always_ff @(posedge CLK_IN)
   begin
      if (SYS_RST_IN || por_low)
      begin
         TEST_MODE_OUT        <= `RSPC_STRAP_RESET;
         TEST_MODE_ACTIVE_OUT <= 1'b0;
         TEST_STRAP_OUT.oe_n  <= 8'hff; // R4
         TEST_STRAP_OUT.data  <= 8'h00;
      end
      else if (strap_take)
      begin
         TEST_MODE_OUT        <= TEST_STRAP_IN; // R5 R13
         TEST_MODE_ACTIVE_OUT <= |TEST_STRAP_IN; // R7
         TEST_STRAP_OUT.oe_n  <= 8'h00; // R6
      end
      else if (TEST_STRAP_OUT.oe_n == 8'h00)
         TEST_STRAP_OUT.data  <= TEST_OBSERVE_IN; // R6
   end

   // =====================================================
   // configuration, park, array enable
   // =====================================================
   rspc_park_timer #(.CYCLES(PARK_CYCLES)) u_park
   (
      .CLK_IN   (CLK_IN),
      .clear_in (park_clear),
      .start_in (parking),
      .done_out (park_done)
   );

   always_ff @(posedge CLK_IN)
   begin
      if (SYS_RST_IN || por_low)
      begin
         CONFIG_START_OUT                <= 1'b0; // R2
         CONFIG_ACTIVE_OUT               <= 1'b0;
         PARK_ACTIVE_OUT                 <= 1'b0;
         ARRAY_DRIVER_ENABLE_RESET_N_OUT <= 1'b0;
         NORMAL_OP_FAULT_OUT             <= 1'b0;
      end
      else
      begin
         CONFIG_START_OUT                <= strap_take; // R1
         CONFIG_ACTIVE_OUT               <= live;
         PARK_ACTIVE_OUT                 <= parking; // R8
         // drop enable once parked, never before
         ARRAY_DRIVER_ENABLE_RESET_N_OUT <= keep_enable; // R12
         // board straps these low; flag misuse rather than act on it
         NORMAL_OP_FAULT_OUT             <= MFG_TEST_ENABLE_IN || SCAN_PORT_RESET_N_IN; // R10 R11
      end
   end

   // =====================================================
   // checks
   // =====================================================
   // cycles since release, held at the top so a long run never wraps
   logic [7:0]              since_rel;
   wire                     since_top = (since_rel == 8'hff);

   always_ff @(posedge CLK_IN)
   begin
      if (park_clear)
         since_rel <= 8'h00;
      else if (!since_top)
         since_rel <= since_rel + 8'h01;
   end

   sequence s_release;
      $rose(POWER_ON_RESET_N_IN);
   endsequence

   sequence s_park_seen;
      live && !FAST_PARK_REQ_N_IN && POWER_ON_RESET_N_IN ##1 POWER_ON_RESET_N_IN;
   endsequence

   a_outputs_inactive: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // R2
      !POWER_ON_RESET_N_IN |=> !CONFIG_ACTIVE_OUT && !ARRAY_DRIVER_ENABLE_RESET_N_OUT
                               && !PARK_ACTIVE_OUT && !CONFIG_START_OUT
                               && !TEST_MODE_ACTIVE_OUT && !NORMAL_OP_FAULT_OUT)
      else $error("output active during reset");

   a_strap_tristate: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // R4
      !POWER_ON_RESET_N_IN |=> TEST_STRAP_OUT.oe_n == 8'hff)
      else $error("strap driven during reset");

   a_strap_sample_time: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // R5
      since_rel == 8'(STRAP_CYCLES + 1) |-> TEST_STRAP_OUT.oe_n == 8'h00 && CONFIG_START_OUT
                                            && TEST_MODE_OUT == $past(TEST_STRAP_IN))
      else $error("strap sample not at delay");

   a_strap_not_early: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // R5
      since_rel != 8'h00 && since_rel <= 8'(STRAP_CYCLES)
      |-> TEST_STRAP_OUT.oe_n == 8'hff && !CONFIG_START_OUT)
      else $error("strap sampled early");

   a_mode_stable: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // R13
      TEST_STRAP_OUT.oe_n == 8'h00 && POWER_ON_RESET_N_IN |=> $stable(TEST_MODE_OUT))
      else $error("test mode changed");

   a_config_start: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // R1
      CONFIG_START_OUT && POWER_ON_RESET_N_IN
      |-> $past(POWER_ON_RESET_N_IN, 2) ##1 (CONFIG_ACTIVE_OUT && !CONFIG_START_OUT))
      else $error("config start without release");

   a_fast_park: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // R8
      s_park_seen |=> PARK_ACTIVE_OUT)
      else $error("park request ignored");

   a_enable_after_park: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // R12
      $fell(ARRAY_DRIVER_ENABLE_RESET_N_OUT) && POWER_ON_RESET_N_IN
      |-> $past(PARK_ACTIVE_OUT) || !$past(POWER_ON_RESET_N_IN))
      else $error("enable dropped before park");

   a_test_mode_flag: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // R7
      TEST_MODE_ACTIVE_OUT == (TEST_MODE_OUT != 8'h00))
      else $error("test mode flag without strap");

   a_release_starts: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // R1
      s_release |=> state == RSPC_WAIT)
      else $error("release did not start sequence");

   a_enable_held: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // R12
      PARK_ACTIVE_OUT |-> ARRAY_DRIVER_ENABLE_RESET_N_OUT)
      else $error("enable dropped while parking");

   a_parked_low: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // R12
      state == RSPC_PARKED |=> !ARRAY_DRIVER_ENABLE_RESET_N_OUT)
      else $error("enable high once parked");

   a_strap_drive: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // R6
      TEST_STRAP_OUT.oe_n == 8'h00 && POWER_ON_RESET_N_IN
      |=> TEST_STRAP_OUT.data == $past(TEST_OBSERVE_IN))
      else $error("strap pins not driving observe data");

endmodule : rspc_ctrl

// *** dv/rspc_pmic_model.sv ***
// power supply controller model: reset, park request, manufacturing test enable and scan port reset pins
`timescale 1ns/100ps

module rspc_pmic_model
(
   input  wire logic CLK_IN,
   output logic      por_n_out,
   output logic      park_n_out,
   output logic      mfg_out,
   output logic      scan_n_out
);
   initial
   begin
      por_n_out  = 1'b0;
      park_n_out = 1'b1;
      mfg_out    = 1'b0;
      scan_n_out = 1'b0;
   end

   // supplies settle first, hence the delay before release
   task automatic release_por(input int settle);
   begin
      repeat (settle) @(posedge CLK_IN);
      por_n_out <= 1'b1;
   end
   endtask : release_por

   task automatic assert_por();
   begin
      @(posedge CLK_IN);
      por_n_out <= 1'b0;
   end
   endtask : assert_por

   // only used on imminent power loss
   task automatic request_park(input int hold);
   begin
      @(posedge CLK_IN);
      park_n_out <= 1'b0;
      repeat (hold) @(posedge CLK_IN);
      park_n_out <= 1'b1;
   end
   endtask : request_park

   // deliberate misuse of one input that the board should hold low
   task automatic misuse(input logic use_mfg);
   begin
      @(posedge CLK_IN);
      if (use_mfg)
         mfg_out <= 1'b1;
      else
         scan_n_out <= 1'b1;
      repeat (2) @(posedge CLK_IN);
      mfg_out    <= 1'b0;
      scan_n_out <= 1'b0;
   end
   endtask : misuse
endmodule : rspc_pmic_model

// *** dv/tb_rspc_ctrl.sv ***
// self-checking bench for the reset, strap and park control block
`timescale 1ns/100ps

module tb_rspc_ctrl;
   import rspc_pkg::*;
   localparam int STRAP = 30;
   localparam int PARK  = 16;
   logic              clk = 1'b0;
   logic              rst = 1'b1;
   logic              por_n, park_n, mfg, scan_n, por_q = 1'b0;
   logic              cfg_start, cfg_act, park_act, en, fault, mode_act;
   logic [7:0]        pull = 8'h00;
   logic [7:0]        obs  = 8'h00;
   logic [7:0]        mode, pins;
   logic [7:0]        cnt  = 8'h00;
   integer            seed = 32'h9835;
   integer            num_errors = 0;
   integer            tests_run  = 0;
   integer            cycles     = 0;
   logic [26:0]       notes[$];
   rspc_strap_drive_t drv;

   always #25 clk = ~clk;
   // weak pulldown unless the board pulls up; design wins once driving
   assign pins = (drv.data & ~drv.oe_n) | (pull & drv.oe_n);

   rspc_pmic_model i_pmic (.CLK_IN(clk), .por_n_out(por_n), .park_n_out(park_n),
      .mfg_out(mfg), .scan_n_out(scan_n));
   rspc_ctrl #(.STRAP_CYCLES(STRAP), .PARK_CYCLES(PARK)) i_dut (.CLK_IN(clk),
      .SYS_RST_IN(rst), .POWER_ON_RESET_N_IN(por_n), .FAST_PARK_REQ_N_IN(park_n),
      .MFG_TEST_ENABLE_IN(mfg), .SCAN_PORT_RESET_N_IN(scan_n), .TEST_STRAP_IN(pins),
      .TEST_OBSERVE_IN(obs), .TEST_STRAP_OUT(drv), .TEST_MODE_OUT(mode),
      .TEST_MODE_ACTIVE_OUT(mode_act), .CONFIG_START_OUT(cfg_start),
      .CONFIG_ACTIVE_OUT(cfg_act), .PARK_ACTIVE_OUT(park_act),
      .ARRAY_DRIVER_ENABLE_RESET_N_OUT(en), .NORMAL_OP_FAULT_OUT(fault));

   task automatic check(input logic [26:0] got, input logic [26:0] exp);
   begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
         num_errors = num_errors + 1;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask : check

   task automatic print_verdict();
   begin
      if (num_errors == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   end
   endtask : print_verdict

   // cycles since the power-on reset was seen released
   always @(posedge clk)
   begin
      por_q  <= por_n;
      cnt    <= (por_n & ~por_q) ? 8'h00 : cnt + 8'h01;
      cycles <= cycles + 1;
      if (cycles == 2000)
      begin
         num_errors = num_errors + 1;
         print_verdict();
      end
   end

   always @(negedge clk)
      if (cfg_start === 1'b1)
         check({2'b00, cnt, mode, mode_act, drv.oe_n}, notes.pop_front());

   initial
   begin
      integer     n;
      logic [7:0] smp;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      for (int k = 0; k < 4; k++)
      begin
         @(posedge clk);
         pull <= (k == 0) ? 8'h00 : 8'($random(seed));
         @(negedge clk);
         check({mode, cfg_act, en, park_act, drv}, {11'h000, 16'h00ff});
         smp = pull;
         // start pulse stands STRAP cycles after the edge that first sees release
         notes.push_back({2'b00, 8'(STRAP), smp, |smp, 8'h00});
         i_pmic.release_por(3);
         repeat (STRAP + 4) @(posedge clk);
         obs  <= 8'($random(seed));
         pull <= ~pull;
         repeat (2) @(negedge clk);
         check({mode, cfg_act, en, park_act, drv}, {smp, 3'b110, obs, 8'h00});
         check({25'h0000000, mode_act, fault}, {25'h0000000, |smp, 1'b0});
         if (k == 1)
         begin
            i_pmic.request_park(2);
            repeat (2) @(negedge clk);
            check({25'h0000000, en, park_act}, {25'h0000000, 2'b11});
            n = 0;
            while (park_act === 1'b1 && n < 40)
            begin
               n = n + 1;
               @(negedge clk);
            end
            check({17'h00000, 8'(n), en, park_act}, {17'h00000, 8'(PARK + 1), 2'b00});
            i_pmic.request_park(2);
            repeat (4) @(negedge clk);
            check({25'h0000000, en, park_act}, 27'h0000000);
         end
         if (k >= 2)
         begin
            i_pmic.misuse(k == 2);
            @(negedge clk);
            check({26'h0000000, fault}, 27'h0000001);
         end
         i_pmic.assert_por();
         repeat (2) @(posedge clk);
      end
      check({26'h0000000, notes.size() == 0}, 27'h0000001);
      print_verdict();
   end
endmodule : tb_rspc_ctrl
